// ==== bench/gpio_setreset_lock_altfunc_bench.sv ====
// Self-checking bench of the port register block over AXI4-Lite.
`include "gpsl_defines.svh"
module gpio_setreset_lock_altfunc_bench
  import gpsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] pin_in, out_data, gp_en, frozen;
  gpsl_cfg_t   cfg;
  int          errors, samples_checked;

  gpsl_top gpsl_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
    .out_data(out_data), .pin_gp_out_en(gp_en), .pin_frozen(frozen),
    .pin_cfg(cfg));

  // Free-running bus clock of 8 ns.
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
      $display("Error at %0t: got %h expected %h", $time, g, e);
    if (g !== e)
      errors++;
  endtask

  // Holds reset low for four clock cycles.
  task automatic rst();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Write; each channel is let go at the rising edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = 2'h0, input logic [3:0] s = 4'hF);
    logic       pa, pw, b;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    b = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      b = bvalid;
      r = bresp;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Read with expected data and response; one edge passes after it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    logic       pa, b;
    logic [1:0] r;
    pa = 1'b1;
    b = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      b = rvalid;
      d = rdata;
      r = rresp;
      pa = pa && !arready;
      arvalid <= pa;
    end
    rready <= 1'b0;
    @(posedge aclk);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Cuts a hung run short.
  initial
  begin
    #20us;
    errors++;
    give_verdict();
  end

  // Main test sequence.
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    pin_in = 16'hA5C3;
    errors = 0;
    samples_checked = 0;
    rst();
    rd(`GPSL_OFS_AFL, 32'h0);
    rd(`GPSL_OFS_LOCK, 32'h0);
    rd(`GPSL_OFS_IN, 32'h0000A5C3);
    $display("reset values test done");
    wr(`GPSL_OFS_OUT, 32'hFFFF00F0);
    rd(`GPSL_OFS_OUT, 32'h000000F0);
    wr(`GPSL_OFS_BSC, 32'h00F1000F);
    rd(`GPSL_OFS_OUT, 32'h0000000F);
    chk({16'h0, out_data}, 32'h0000000F);
    rd(`GPSL_OFS_BSC, 32'h0);
    wr(`GPSL_OFS_BCO, 32'hFFFF0003);
    rd(`GPSL_OFS_OUT, 32'h0000000C);
    rd(`GPSL_OFS_BCO, 32'h0);
    $display("set and clear test done");
    wr(`GPSL_OFS_AFL, 32'hFEDCBA98);
    wr(`GPSL_OFS_AFH, 32'h76543210);
    rd(`GPSL_OFS_AFL, 32'hFEDCBA98);
    rd(`GPSL_OFS_AFH, 32'h76543210);
    chk(cfg.af_high, 32'h76543210);
    wr(`GPSL_OFS_MODE, 32'h00000009);
    chk({16'h0, gp_en}, 32'h00000001);
    $display("selector and mode test done");
    wr(`GPSL_OFS_LOCK, 32'h00010003);
    wr(`GPSL_OFS_LOCK, 32'h00000003);
    wr(`GPSL_OFS_LOCK, 32'h00010007);
    rd(`GPSL_OFS_LOCK, 32'h00000007);
    chk({16'h0, frozen}, 32'h0);
    wr(`GPSL_OFS_LOCK, 32'h00010003);
    wr(`GPSL_OFS_LOCK, 32'h00000003, 2'h0, 4'h3);
    wr(`GPSL_OFS_LOCK, 32'h00010003, 2'h0, 4'h7);
    rd(`GPSL_OFS_LOCK, 32'h00000003);
    wr(`GPSL_OFS_LOCK, 32'h00000003);
    wr(`GPSL_OFS_LOCK, 32'h00010003);
    wr(`GPSL_OFS_LOCK, 32'h00000003);
    wr(`GPSL_OFS_LOCK, 32'h00010003);
    rd(`GPSL_OFS_LOCK, 32'h00010003);
    chk({16'h0, frozen}, 32'h00000003);
    wr(`GPSL_OFS_MODE, 32'hFFFFFFFF);
    rd(`GPSL_OFS_MODE, 32'hFFFFFFF9);
    wr(`GPSL_OFS_AFL, 32'h11111111);
    rd(`GPSL_OFS_AFL, 32'h11111198);
    rd(`GPSL_OFS_IN, 32'h00000003);
    wr(`GPSL_OFS_OTYPE, 32'hFFFFFFFF);
    rd(`GPSL_OFS_OTYPE, 32'h0000FFFC);
    wr(`GPSL_OFS_SPEED, 32'hFFFFFFFF);
    rd(`GPSL_OFS_SPEED, 32'hFFFFFFF0);
    wr(`GPSL_OFS_PULL, 32'hFFFFFFFF);
    chk(cfg.pull, 32'hFFFFFFF0);
    wr(`GPSL_OFS_LOCK, 32'h0000FFFF);
    rd(`GPSL_OFS_LOCK, 32'h00010003);
    $display("lock test done");
    wr(8'h2C, 32'h00000001, 2'h2);
    rd(8'h2C, 32'h0, 2'h2);
    rst();
    rd(`GPSL_OFS_LOCK, 32'h0);
    rd(`GPSL_OFS_MODE, 32'h0);
    $display("unmapped and second reset test done");
    give_verdict();
  end
endmodule // gpio_setreset_lock_altfunc_bench

// ==== verilog/gpsl_defines.svh ====
// Register offsets, field positions, reset values and bus codes.
`ifndef GPSL_DEFINES_SVH
`define GPSL_DEFINES_SVH

`define GPSL_ADDR_W      8
`define GPSL_PINS        16
`define GPSL_OFS_MODE    8'h00
`define GPSL_OFS_OTYPE   8'h04
`define GPSL_OFS_SPEED   8'h08
`define GPSL_OFS_PULL    8'h0C
`define GPSL_OFS_IN      8'h10
`define GPSL_OFS_OUT     8'h14
`define GPSL_OFS_BSC     8'h18
`define GPSL_OFS_LOCK    8'h1C
`define GPSL_OFS_AFL     8'h20
`define GPSL_OFS_AFH     8'h24
`define GPSL_OFS_BCO     8'h28
`define GPSL_KEY_BIT     16
`define GPSL_RST_WORD    32'h00000000
`define GPSL_RST_HALF    16'h0000
`define GPSL_RESP_OKAY   2'h0
`define GPSL_RESP_SLVERR 2'h2

`endif

// ==== verilog/gpsl_lock_ctl.sv ====
// Per-pin lock bits and the three-write lock key sequence.
`include "gpsl_defines.svh"
module gpsl_lock_ctl
  import gpsl_pkg::*;
(
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write to the lock register.
  input  wire logic             wr_lock,
  input  wire logic [31:0]      wr_data,
  input  wire logic [31:0]      wr_mask,
  // Lock state.
  output logic      [15:0]      pin_lock_bits,
  output logic                  lock_key,
  output gpsl_lock_state_t      lock_state
);

  gpsl_lock_state_t state_reg;
  gpsl_lock_state_t state_next;
  logic [15:0]      bits_reg;
  logic             full;
  logic             key;
  logic             same;

  assign full = (wr_mask == 32'hFFFFFFFF);
  assign key  = wr_data[`GPSL_KEY_BIT];
  assign same = (wr_data[15:0] == bits_reg);

  // Sequence: key one, key zero, key one, all with unchanged lock bits.
  always_comb
  begin
    state_next = state_reg;
    if (wr_lock)
    begin
      unique case (state_reg)
        GPSL_LK_IDLE: state_next = (full && key) ? GPSL_LK_ONE
                                                 : GPSL_LK_IDLE;
        GPSL_LK_ONE:  state_next = (full && !key && same) ? GPSL_LK_ZERO
                                                          : GPSL_LK_IDLE;
        GPSL_LK_ZERO: state_next = (full && key && same) ? GPSL_LK_DONE
                                                         : GPSL_LK_IDLE;
        GPSL_LK_DONE: state_next = GPSL_LK_DONE;
        default:      state_next = GPSL_LK_IDLE;
      endcase
    end
  end

  // Sequence state; only reset leaves the locked state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= GPSL_LK_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Lock bits take writes only while the key reads zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bits_reg <= `GPSL_RST_HALF;
    end
    else if (wr_lock && state_reg != GPSL_LK_DONE)
    begin
      bits_reg <= (bits_reg & ~wr_mask[15:0]) |
                  (wr_data[15:0] & wr_mask[15:0]);
    end
  end

  assign pin_lock_bits = bits_reg;
  assign lock_key      = (state_reg == GPSL_LK_DONE);
  assign lock_state    = state_reg;

endmodule // gpsl_lock_ctl

// ==== verilog/gpsl_out_data.sv ====
// Output data register with atomic set and clear updates.
`include "gpsl_defines.svh"
module gpsl_out_data
  import gpsl_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write requests, at most one per cycle.
  input  wire logic        wr_out,
  input  wire logic        wr_bsc,
  input  wire logic        wr_bco,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] wr_mask,
  // Output data bits.
  output logic      [15:0] out_data
);

  logic [15:0] out_data_reg;
  logic [31:0] md;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;

  // Decodes the set and clear masks from the strobed write word.
  always_comb
  begin
    md       = wr_data & wr_mask;
    set_bits = wr_bsc ? md[15:0] : `GPSL_RST_HALF;
    clr_bits = wr_bsc ? md[31:16] : `GPSL_RST_HALF;
    if (wr_bco)
    begin
      clr_bits = md[15:0];
    end
  end

  // All affected bits change together on one edge; set beats clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_data_reg <= `GPSL_RST_HALF;
    end
    else if (wr_out)
    begin
      out_data_reg <= (out_data_reg & ~wr_mask[15:0]) |
                      (wr_data[15:0] & wr_mask[15:0]);
    end
    else
    begin
      out_data_reg <= (out_data_reg & ~clr_bits) | set_bits;
    end
  end

  assign out_data = out_data_reg;

endmodule // gpsl_out_data

// ==== verilog/gpsl_pkg.sv ====
// Types and shared helper functions of the port register block.
package gpsl_pkg;

  // Per-pin 2-bit mode field encoding.
  typedef enum logic [1:0] {
    GPSL_MODE_INPUT  = 2'h0,
    GPSL_MODE_OUTPUT = 2'h1,
    GPSL_MODE_ALT    = 2'h2,
    GPSL_MODE_ANALOG = 2'h3
  } gpsl_mode_t;

  // Lock key sequence states, one-hot.
  typedef enum logic [3:0] {
    GPSL_LK_IDLE = 4'h1,
    GPSL_LK_ONE  = 4'h2,
    GPSL_LK_ZERO = 4'h4,
    GPSL_LK_DONE = 4'h8
  } gpsl_lock_state_t;

  // Pin configuration carried to the pad logic.
  typedef struct packed {
    logic [31:0] mode;
    logic [15:0] otype;
    logic [31:0] speed;
    logic [31:0] pull;
    logic [31:0] af_low;
    logic [31:0] af_high;
  } gpsl_cfg_t;

  // Expands the four write strobes into a 32-bit bit mask.
  function automatic logic [31:0] gpsl_strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Merges new data into old data where the mask is one.
  function automatic logic [31:0] gpsl_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

// ==== verilog/gpsl_top.sv ====
// Register block of a 16-pin port behind an AXI4-Lite slave.
//
// How it works
// - Upper set/clear bits clear output bits.
// - Lower set/clear bits set output bits.
// - Set wins when set and clear coincide.
// - Set/clear register always reads zero.
// - Clear-only register clears bits, reads zero.
// - Key written one, zero, one arms lock.
// - Changed lock bits or order abort sequence.
// - Locked pins freeze all configuration fields.
// - Key stays one; lock register frozen.
// - Lock bits writable only while key zero.
// - Key readable always, changed only by sequence.
// - Low selector register: 4 bits, pins 0-7.
// - High selector register: 4 bits, pins 8-15.
// - Lock bit one marks pin locked.
// - Mode codes input, output, alternate, analog.
// - Output data low half read/write.
//
// Register access over AXI4-Lite is this design's own decision.
`include "gpsl_defines.svh"
module gpsl_top
  import gpsl_pkg::*;
(
  // Clock and reset.
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [`GPSL_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read address channel.
  input  wire logic [`GPSL_ADDR_W-1:0] araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Pad side.
  input  wire logic [15:0]             pin_in,
  output logic [15:0]                  out_data,
  output logic [15:0]                  pin_gp_out_en,
  output logic [15:0]                  pin_frozen,
  output gpsl_cfg_t                    pin_cfg
);

  // Write channel holding registers.
  logic                    aw_held_reg;
  logic [`GPSL_ADDR_W-1:0] aw_addr_reg;
  logic                    w_held_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  // Read channel registers.
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;
  logic [31:0]             rdata_next;
  // Storage and derived signals.
  gpsl_cfg_t               cfg_reg;
  logic [15:0]             in_data_reg;
  logic [15:0]             analog_pins;
  logic                    wr_fire;
  logic [31:0]             wr_mask;
  logic [31:0]             wr_md;
  logic [15:0]             pin_lock_bits;
  logic                    lock_key;
  gpsl_lock_state_t        lock_state;
  logic [15:0]             frozen;
  logic [31:0]             frz2;
  logic [31:0]             frz4_low;
  logic [31:0]             frz4_high;

  // Word-aligned offsets up to the clear-only register are mapped.
  function automatic logic is_mapped(input logic [`GPSL_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= `GPSL_OFS_BCO);
  endfunction

  // Spreads one mask bit per pin over a field of the given width.
  function automatic logic [31:0] spread(input logic [15:0] m,
                                         input int unsigned w);
    logic [31:0] r;
    r = `GPSL_RST_WORD;
    for (int i = 0; i < 16; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (j < w && i * w + j < 32)
        begin
          r[i * w + j] = m[i];
        end
      end
    end
    return r;
  endfunction

  // Channel readiness: one write and one read in flight.
  assign awready = !aw_held_reg;
  assign wready  = !w_held_reg;
  assign arready = !rvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_mask = gpsl_strb_mask(w_strb_reg);
  assign wr_md   = w_data_reg & wr_mask;

  // Address and data may arrive in either order; each is held once taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= `GPSL_RST_WORD;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      else if (wr_fire)
      begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response follows the register update on the same edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `GPSL_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(aw_addr_reg) ? `GPSL_RESP_OKAY
                                           : `GPSL_RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // Freeze masks for fields of one, two and four bits per pin.
  assign frozen    = lock_key ? pin_lock_bits : `GPSL_RST_HALF;
  assign frz2      = spread(frozen, 2);
  assign frz4_low  = spread({8'h00, frozen[7:0]}, 4);
  assign frz4_high = spread({8'h00, frozen[15:8]}, 4);

  // Configuration registers; locked pins keep their fields.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= '0;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr_reg)
        `GPSL_OFS_MODE:
          cfg_reg.mode <= gpsl_merge(cfg_reg.mode, w_data_reg,
                                     wr_mask & ~frz2);
        `GPSL_OFS_OTYPE:
          cfg_reg.otype <= (cfg_reg.otype & ~(wr_mask[15:0] & ~frozen)) |
                           (w_data_reg[15:0] & wr_mask[15:0] & ~frozen);
        `GPSL_OFS_SPEED:
          cfg_reg.speed <= gpsl_merge(cfg_reg.speed, w_data_reg,
                                      wr_mask & ~frz2);
        `GPSL_OFS_PULL:
          cfg_reg.pull <= gpsl_merge(cfg_reg.pull, w_data_reg,
                                     wr_mask & ~frz2);
        `GPSL_OFS_AFL:
          cfg_reg.af_low <= gpsl_merge(cfg_reg.af_low, w_data_reg,
                                       wr_mask & ~frz4_low);
        `GPSL_OFS_AFH:
          cfg_reg.af_high <= gpsl_merge(cfg_reg.af_high, w_data_reg,
                                        wr_mask & ~frz4_high);
        default:
          cfg_reg <= cfg_reg;
      endcase
    end
  end

  assign pin_cfg    = cfg_reg;
  assign pin_frozen = frozen;

  // Per-pin mode decode: analog pins read zero, output pins drive data.
  always_comb
  begin
    analog_pins   = `GPSL_RST_HALF;
    pin_gp_out_en = `GPSL_RST_HALF;
    for (int i = 0; i < 16; i++)
    begin
      analog_pins[i]   = gpsl_mode_t'(cfg_reg.mode[2 * i +: 2]) ==
                         GPSL_MODE_ANALOG;
      pin_gp_out_en[i] = gpsl_mode_t'(cfg_reg.mode[2 * i +: 2]) ==
                         GPSL_MODE_OUTPUT;
    end
  end

  // Pin levels are sampled every clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_data_reg <= `GPSL_RST_HALF;
    end
    else
    begin
      in_data_reg <= pin_in & ~analog_pins;
    end
  end

  // Output data register with set/clear and clear-only updates.
  gpsl_out_data u_out_data (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_out   (wr_fire && aw_addr_reg == `GPSL_OFS_OUT),
    .wr_bsc   (wr_fire && aw_addr_reg == `GPSL_OFS_BSC),
    .wr_bco   (wr_fire && aw_addr_reg == `GPSL_OFS_BCO),
    .wr_data  (w_data_reg),
    .wr_mask  (wr_mask),
    .out_data (out_data)
  );

  // Lock bits and key sequence.
  gpsl_lock_ctl u_lock_ctl (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .wr_lock       (wr_fire && aw_addr_reg == `GPSL_OFS_LOCK),
    .wr_data       (w_data_reg),
    .wr_mask       (wr_mask),
    .pin_lock_bits (pin_lock_bits),
    .lock_key      (lock_key),
    .lock_state    (lock_state)
  );

  // Read data selection; write-only registers return zero.
  always_comb
  begin
    unique case (araddr)
      `GPSL_OFS_MODE:  rdata_next = cfg_reg.mode;
      `GPSL_OFS_OTYPE: rdata_next = {16'h0000, cfg_reg.otype};
      `GPSL_OFS_SPEED: rdata_next = cfg_reg.speed;
      `GPSL_OFS_PULL:  rdata_next = cfg_reg.pull;
      `GPSL_OFS_IN:    rdata_next = {16'h0000, in_data_reg};
      `GPSL_OFS_OUT:   rdata_next = {16'h0000, out_data};
      `GPSL_OFS_BSC:   rdata_next = `GPSL_RST_WORD;
      `GPSL_OFS_LOCK:  rdata_next = {15'h0000, lock_key,
                                     pin_lock_bits};
      `GPSL_OFS_AFL:   rdata_next = cfg_reg.af_low;
      `GPSL_OFS_AFH:   rdata_next = cfg_reg.af_high;
      `GPSL_OFS_BCO:   rdata_next = `GPSL_RST_WORD;
      default:         rdata_next = `GPSL_RST_WORD;
    endcase
  end

  // Read answer is registered on the same edge that takes the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= `GPSL_RST_WORD;
      rresp_reg  <= `GPSL_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= is_mapped(araddr) ? `GPSL_RESP_OKAY
                                      : `GPSL_RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;

  // Clear request without set leaves the bit low after the write.
  bsc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_BSC) |=>
      ((out_data & $past(wr_md[31:16] & ~wr_md[15:0])) == 16'h0000))
    else $error("Clear bit did not clear the output bit.");

  // Set request leaves the bit high, also when clear is requested too.
  bsc_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_BSC) |=>
      ((out_data & $past(wr_md[15:0])) == $past(wr_md[15:0])))
    else $error("Set bit did not set the output bit.");

  // Untouched output bits keep their value across a set/clear write.
  bsc_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_BSC) |=>
      (((out_data ^ $past(out_data)) &
        ~$past(wr_md[31:16] | wr_md[15:0])) == 16'h0000))
    else $error("Set/clear write changed an unselected output bit.");

  // Write-only registers answer reads with zero.
  wo_read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && (araddr == `GPSL_OFS_BSC ||
                            araddr == `GPSL_OFS_BCO)) |=>
      (rvalid && rdata == 32'h00000000))
    else $error("Write-only register returned nonzero data.");

  // Clear-only write clears the chosen bits and leaves the rest.
  bco_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_BCO) |=>
      (out_data == ($past(out_data) & ~$past(wr_md[15:0]))))
    else $error("Clear-only write gave the wrong output data.");

  // The key turns on only at the third step of the sequence.
  key_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(lock_key) |->
      ($past(lock_state) == GPSL_LK_ZERO && $past(w_data_reg[16]) &&
       $past(w_data_reg[15:0]) == pin_lock_bits))
    else $error("Lock key rose outside the key sequence.");

  // Changed lock bits at the second step return the sequence to idle.
  seq_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_LOCK &&
     lock_state == GPSL_LK_ONE && w_data_reg[15:0] != pin_lock_bits) |=>
      (lock_state == GPSL_LK_IDLE))
    else $error("Changed lock bits did not abort the sequence.");

  // Once set, the key and the lock bits hold until reset.
  key_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_key |=> (lock_key && $stable(pin_lock_bits)))
    else $error("Lock register changed after the key was set.");

  // Locked pins keep their mode and low selector fields.
  cfg_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_key |=> ((((cfg_reg.mode ^ $past(cfg_reg.mode)) & frz2) |
                   ((cfg_reg.af_low ^ $past(cfg_reg.af_low)) & frz4_low))
                  == 32'h00000000))
    else $error("Locked pin configuration changed.");

  // Full-word write to a free high selector lands exactly.
  afh_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_reg == `GPSL_OFS_AFH && w_strb_reg == 4'hF &&
     frozen == 16'h0000) |=> (cfg_reg.af_high == $past(w_data_reg)))
    else $error("High selector write was not stored.");

  // A write answer comes one edge after both channels are held.
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bvalid) |-> $past(aw_held_reg && w_held_reg))
    else $error("Write response without a held write.");

endmodule // gpsl_top
